// File: shared/tap_consts.svh
`ifndef TAP_CONSTS_SVH
`define TAP_CONSTS_SVH
`define TAP_THRESHOLD_OFS   6'h1D
`define TAP_MAX_LENGTH_OFS  6'h21
`define TAP_QUIET_GAP_OFS   6'h22
`define SECOND_TAP_SPAN_OFS 6'h23
`define TAP_AXIS_CTRL_OFS   6'h2A
`define MOTION_STATUS_OFS   6'h2B
`define IRQ_ENABLE_OFS      6'h2E
`define IRQ_CAUSE_OFS       6'h30
`define IRQ_SINGLE_BIT      6
`define IRQ_DOUBLE_BIT      5
`define IRQ_ACT_BIT         4
`define IRQ_INACT_BIT       3
`define AXIS_SUPPRESS_BIT   3
`define STATUS_ASLEEP_BIT   3
`define REG_RESET_VAL       8'h00
`define GAP_SCALE_SHIFT     1
`endif

// File: shared/tap_pkg.sv
package tap_pkg;
  typedef enum logic [5:0] {
    ST_IDLE  = 6'b000001,
    ST_FIRST = 6'b000010,
    ST_QUIET = 6'b000100,
    ST_SPAN  = 6'b001000,
    ST_SECND = 6'b010000,
    ST_DRAIN = 6'b100000
  } tap_state_t;
  typedef logic [7:0] reg_byte_t;
  typedef logic [5:0] reg_addr_t;
  typedef logic [15:0] sample_t;
endpackage

// File: design/tap_detect_and_link_sleep.sv
`timescale 1ns/1ps
`default_nettype none
`include "tap_consts.svh"
// Behaviour
// - compare acceleration with tap threshold register
// - longest tap length from its register
// - quiet gap timed after first tap ends
// - second tap starts inside span window
// - single only: report at fall below threshold
// - double enabled, gap and span nonzero: single waits for double outcome
// - suppress: spike in gap kills double
// - above threshold at window open kills double
// - overlong second tap kills double
// - enable bits gate single and double flags
// - per-axis participation bits
// - first axis recorded, never cleared
// - undecimated samples unless improved tap mode
// - link: activity armed only after inactivity
// - no auto-sleep while activity flag pending
// - asleep bit in status register
// - link toggles activity and inactivity arming
module tap_detect_and_link_sleep
  import tap_pkg::*;
(
  input  wire logic           core_clk,
  input  wire logic           rst_n,
  input  wire logic           link_clk,
  input  wire logic           reg_req,
  input  wire logic           reg_write,
  input  wire tap_pkg::reg_addr_t reg_addr,
  input  wire tap_pkg::reg_byte_t reg_wdata,
  output var  logic           reg_busy,
  output var  logic           reg_done,
  output var  tap_pkg::reg_byte_t reg_rdata,
  input  wire tap_pkg::sample_t   sample_x,
  input  wire tap_pkg::sample_t   sample_y,
  input  wire tap_pkg::sample_t   sample_z,
  input  wire logic           sample_valid,
  input  wire logic           odr_valid,
  input  wire logic           improved_tap,
  input  wire logic           act_event,
  input  wire logic           inact_event,
  input  wire logic           link_enable,
  input  wire logic           auto_sleep,
  output var  logic           irq_out,
  output var  logic           asleep
);
  import tap_pkg::*;

  function automatic logic [15:0] magnitude(input logic [15:0] s);
    magnitude = s[15] ? (16'h0000 - s) : s;
  endfunction

  // threshold lsb is sixteen sample lsbs
  function automatic logic crosses(input logic [15:0] s, input logic [7:0] thr);
    crosses = magnitude(s) >= {4'h0, thr, 4'h0};
  endfunction

  // link domain: request capture and answer
  logic       lk_req_tgl_q, lk_req_tgl_d;
  logic       lk_busy_q, lk_busy_d;
  logic       lk_done_q, lk_done_d;
  logic       lk_wr_q, lk_wr_d;
  reg_addr_t  lk_addr_q, lk_addr_d;
  reg_byte_t  lk_wdata_q, lk_wdata_d;
  reg_byte_t  lk_rdata_q, lk_rdata_d;
  logic       lk_ack_s1_q, lk_ack_s2_q, lk_ack_s3_q;
  logic       lk_ack_pulse;
  logic       core_ack_tgl_q, core_ack_tgl_d;
  reg_byte_t  core_rdata_q, core_rdata_d;

  assign lk_ack_pulse = lk_ack_s2_q ^ lk_ack_s3_q;

  always_comb begin
    lk_req_tgl_d = lk_req_tgl_q;
    lk_busy_d    = lk_busy_q;
    lk_done_d    = 1'b0;
    lk_wr_d      = lk_wr_q;
    lk_addr_d    = lk_addr_q;
    lk_wdata_d   = lk_wdata_q;
    lk_rdata_d   = lk_rdata_q;
    // fields stay frozen while busy so the core may read them directly
    if (reg_req && !lk_busy_q) begin
      lk_req_tgl_d = ~lk_req_tgl_q;
      lk_busy_d    = 1'b1;
      lk_wr_d      = reg_write;
      lk_addr_d    = reg_addr;
      lk_wdata_d   = reg_wdata;
    end
    if (lk_ack_pulse) begin
      lk_busy_d  = 1'b0;
      lk_done_d  = 1'b1;
      lk_rdata_d = core_rdata_q;
    end
  end

  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      lk_req_tgl_q <= 1'b0;
      lk_busy_q    <= 1'b0;
      lk_done_q    <= 1'b0;
      lk_wr_q      <= 1'b0;
      lk_addr_q    <= 6'h00;
      lk_wdata_q   <= 8'h00;
      lk_rdata_q   <= 8'h00;
      lk_ack_s1_q  <= 1'b0;
      lk_ack_s2_q  <= 1'b0;
      lk_ack_s3_q  <= 1'b0;
    end else begin
      lk_req_tgl_q <= lk_req_tgl_d;
      lk_busy_q    <= lk_busy_d;
      lk_done_q    <= lk_done_d;
      lk_wr_q      <= lk_wr_d;
      lk_addr_q    <= lk_addr_d;
      lk_wdata_q   <= lk_wdata_d;
      lk_rdata_q   <= lk_rdata_d;
      lk_ack_s1_q  <= core_ack_tgl_q;
      lk_ack_s2_q  <= lk_ack_s1_q;
      lk_ack_s3_q  <= lk_ack_s2_q;
    end
  end

  assign reg_busy  = lk_busy_q;
  assign reg_done  = lk_done_q;
  assign reg_rdata = lk_rdata_q;

  // core domain: register file
  logic       req_s1_q, req_s2_q, req_s3_q;
  logic       req_pulse, rd_cause;
  reg_byte_t  thr_q, thr_d;
  reg_byte_t  maxlen_q, maxlen_d;
  reg_byte_t  gap_q, gap_d;
  reg_byte_t  span_q, span_d;
  reg_byte_t  axis_ctl_q, axis_ctl_d;
  reg_byte_t  irq_en_q, irq_en_d;
  reg_byte_t  cause_q, cause_d;
  logic [2:0] tap_axis_q, tap_axis_d;
  logic       asleep_q, asleep_d;
  logic       act_armed_q, act_armed_d;
  logic       inact_armed_q, inact_armed_d;
  logic       act_seen, inact_seen;
  logic       single_evt, double_evt;
  logic [2:0] first_axis_q;
  reg_byte_t  rd_val;

  assign req_pulse  = req_s2_q ^ req_s3_q;
  assign rd_cause   = req_pulse && !lk_wr_q && (lk_addr_q == `IRQ_CAUSE_OFS);
  assign act_seen   = act_event && (!link_enable || act_armed_q);
  assign inact_seen = inact_event && (!link_enable || inact_armed_q);

  always_comb begin
    thr_d          = thr_q;
    maxlen_d       = maxlen_q;
    gap_d          = gap_q;
    span_d         = span_q;
    axis_ctl_d     = axis_ctl_q;
    irq_en_d       = irq_en_q;
    cause_d        = cause_q;
    tap_axis_d     = tap_axis_q;
    asleep_d       = asleep_q;
    act_armed_d    = act_armed_q;
    inact_armed_d  = inact_armed_q;
    core_ack_tgl_d = core_ack_tgl_q;
    core_rdata_d   = core_rdata_q;
    case (lk_addr_q)
      `TAP_THRESHOLD_OFS:   rd_val = thr_q;
      `TAP_MAX_LENGTH_OFS:  rd_val = maxlen_q;
      `TAP_QUIET_GAP_OFS:   rd_val = gap_q;
      `SECOND_TAP_SPAN_OFS: rd_val = span_q;
      `TAP_AXIS_CTRL_OFS:   rd_val = {4'h0, axis_ctl_q[3:0]};
      `MOTION_STATUS_OFS:   rd_val = {4'h0, asleep_q, tap_axis_q};
      `IRQ_ENABLE_OFS:      rd_val = irq_en_q;
      `IRQ_CAUSE_OFS:       rd_val = cause_q;
      default:              rd_val = 8'h00;
    endcase
    if (req_pulse) begin
      core_ack_tgl_d = ~core_ack_tgl_q;
      if (lk_wr_q) begin
        case (lk_addr_q)
          `TAP_THRESHOLD_OFS:   thr_d      = lk_wdata_q;
          `TAP_MAX_LENGTH_OFS:  maxlen_d   = lk_wdata_q;
          `TAP_QUIET_GAP_OFS:   gap_d      = lk_wdata_q;
          `SECOND_TAP_SPAN_OFS: span_d     = lk_wdata_q;
          `TAP_AXIS_CTRL_OFS:   axis_ctl_d = {4'h0, lk_wdata_q[3:0]};
          `IRQ_ENABLE_OFS:      irq_en_d   = lk_wdata_q;
          default:              thr_d      = thr_q;
        endcase
      end else begin
        core_rdata_d = rd_val;
      end
    end
    // clear first, then sets, so an event in the read cycle survives
    if (rd_cause) begin
      cause_d = 8'h00;
    end
    if (single_evt && irq_en_q[`IRQ_SINGLE_BIT]) begin
      cause_d[`IRQ_SINGLE_BIT] = 1'b1;
    end
    if (double_evt && irq_en_q[`IRQ_DOUBLE_BIT]) begin
      cause_d[`IRQ_DOUBLE_BIT] = 1'b1;
    end
    if (act_seen && irq_en_q[`IRQ_ACT_BIT]) begin
      cause_d[`IRQ_ACT_BIT] = 1'b1;
    end
    if (inact_seen && irq_en_q[`IRQ_INACT_BIT]) begin
      cause_d[`IRQ_INACT_BIT] = 1'b1;
    end
    if ((single_evt && irq_en_q[`IRQ_SINGLE_BIT]) ||
        (double_evt && irq_en_q[`IRQ_DOUBLE_BIT])) begin
      tap_axis_d = first_axis_q;
    end
    if (link_enable) begin
      if (inact_seen) begin
        inact_armed_d = 1'b0;
        act_armed_d   = 1'b1;
      end
      if (act_seen) begin
        act_armed_d   = 1'b0;
        inact_armed_d = 1'b1;
      end
    end else begin
      // both flag freely here; activity stays disarmed until link mode sees inactivity
      act_armed_d   = 1'b0;
      inact_armed_d = 1'b1;
    end
    if (act_seen) begin
      asleep_d = 1'b0;
    end else if (inact_seen && link_enable && auto_sleep && !cause_q[`IRQ_ACT_BIT]) begin
      asleep_d = 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      req_s1_q       <= 1'b0;
      req_s2_q       <= 1'b0;
      req_s3_q       <= 1'b0;
      thr_q          <= `REG_RESET_VAL;
      maxlen_q       <= `REG_RESET_VAL;
      gap_q          <= `REG_RESET_VAL;
      span_q         <= `REG_RESET_VAL;
      axis_ctl_q     <= `REG_RESET_VAL;
      irq_en_q       <= `REG_RESET_VAL;
      cause_q        <= `REG_RESET_VAL;
      tap_axis_q     <= 3'b000;
      asleep_q       <= 1'b0;
      act_armed_q    <= 1'b0;
      inact_armed_q  <= 1'b1;
      core_ack_tgl_q <= 1'b0;
      core_rdata_q   <= 8'h00;
    end else begin
      req_s1_q       <= lk_req_tgl_q;
      req_s2_q       <= req_s1_q;
      req_s3_q       <= req_s2_q;
      thr_q          <= thr_d;
      maxlen_q       <= maxlen_d;
      gap_q          <= gap_d;
      span_q         <= span_d;
      axis_ctl_q     <= axis_ctl_d;
      irq_en_q       <= irq_en_d;
      cause_q        <= cause_d;
      tap_axis_q     <= tap_axis_d;
      asleep_q       <= asleep_d;
      act_armed_q    <= act_armed_d;
      inact_armed_q  <= inact_armed_d;
      core_ack_tgl_q <= core_ack_tgl_d;
      core_rdata_q   <= core_rdata_d;
    end
  end

  assign irq_out = |(cause_q & irq_en_q);
  assign asleep  = asleep_q;

  // core domain: tap detector
  tap_state_t st_q, st_d;
  logic [8:0] cnt_q, cnt_d;
  logic [2:0] first_axis_d;
  logic [2:0] hit;
  logic       strobe, above, dbl_path;
  logic [8:0] cnt_inc, len_lim, gap_lim, span_lim;

  // improved mode trades bandwidth for echo rejection at the output rate
  assign strobe   = improved_tap ? odr_valid : sample_valid;
  assign hit      = {crosses(sample_z, thr_q), crosses(sample_y, thr_q),
                     crosses(sample_x, thr_q)} & axis_ctl_q[2:0];
  assign above    = |hit;
  assign dbl_path = irq_en_q[`IRQ_DOUBLE_BIT] && (gap_q != 8'h00) && (span_q != 8'h00);
  assign cnt_inc  = cnt_q + 9'h001;
  assign len_lim  = {1'b0, maxlen_q};
  assign gap_lim  = {gap_q, 1'b0} << (`GAP_SCALE_SHIFT - 1);
  assign span_lim = {span_q, 1'b0} << (`GAP_SCALE_SHIFT - 1);

  always_comb begin
    st_d         = st_q;
    cnt_d        = cnt_q;
    first_axis_d = first_axis_q;
    single_evt   = 1'b0;
    double_evt   = 1'b0;
    if (strobe) begin
      case (st_q)
        ST_IDLE: begin
          if (above) begin
            st_d         = ST_FIRST;
            cnt_d        = 9'h001;
            // lowest set axis when several cross together
            first_axis_d = hit & (~hit + 3'b001);
          end
        end
        ST_FIRST: begin
          if (above) begin
            if (cnt_inc > len_lim) begin
              st_d = ST_DRAIN;
            end else begin
              cnt_d = cnt_inc;
            end
          end else if (dbl_path) begin
            st_d  = ST_QUIET;
            cnt_d = 9'h000;
          end else begin
            single_evt = 1'b1;
            st_d       = ST_IDLE;
          end
        end
        ST_QUIET: begin
          if (above && axis_ctl_q[`AXIS_SUPPRESS_BIT]) begin
            single_evt = 1'b1;
            st_d       = ST_DRAIN;
          end else if (cnt_inc >= gap_lim) begin
            if (above) begin
              single_evt = 1'b1;
              st_d       = ST_DRAIN;
            end else begin
              st_d  = ST_SPAN;
              cnt_d = 9'h000;
            end
          end else begin
            cnt_d = cnt_inc;
          end
        end
        ST_SPAN: begin
          if (above) begin
            st_d  = ST_SECND;
            cnt_d = 9'h001;
          end else if (cnt_inc >= span_lim) begin
            single_evt = 1'b1;
            st_d       = ST_IDLE;
          end else begin
            cnt_d = cnt_inc;
          end
        end
        ST_SECND: begin
          if (above) begin
            if (cnt_inc > len_lim) begin
              single_evt = 1'b1;
              st_d       = ST_DRAIN;
            end else begin
              cnt_d = cnt_inc;
            end
          end else begin
            single_evt = 1'b1;
            double_evt = 1'b1;
            st_d       = ST_IDLE;
          end
        end
        ST_DRAIN: begin
          if (!above) begin
            st_d = ST_IDLE;
          end
        end
        default: begin
          st_d  = ST_IDLE;
          cnt_d = 9'h000;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q         <= ST_IDLE;
      cnt_q        <= 9'h000;
      first_axis_q <= 3'b000;
    end else begin
      st_q         <= st_d;
      cnt_q        <= cnt_d;
      first_axis_q <= first_axis_d;
    end
  end

  // checks
  property p_flag_needs_enable;
    @(posedge core_clk) disable iff (!rst_n)
    $rose(cause_q[`IRQ_SINGLE_BIT]) |-> $past(irq_en_q[`IRQ_SINGLE_BIT]);
  endproperty
  a_flag_needs_enable: assert property (p_flag_needs_enable) else $error("single flag set while masked");

  property p_cause_read_clears;
    @(posedge core_clk) disable iff (!rst_n)
    rd_cause && !single_evt && !double_evt && !act_seen && !inact_seen |=> cause_q == 8'h00;
  endproperty
  a_cause_read_clears: assert property (p_cause_read_clears) else $error("cause not cleared by read");

  property p_sleep_blocked;
    @(posedge core_clk) disable iff (!rst_n)
    $rose(asleep_q) |-> !$past(cause_q[`IRQ_ACT_BIT]) && $past(link_enable);
  endproperty
  a_sleep_blocked: assert property (p_sleep_blocked) else $error("slept with activity pending");

  property p_link_swap;
    @(posedge core_clk) disable iff (!rst_n)
    link_enable && inact_seen && !act_seen |=> act_armed_q && !inact_armed_q;
  endproperty
  a_link_swap: assert property (p_link_swap) else $error("link arming not swapped");

  property p_suppress_kills;
    @(posedge core_clk) disable iff (!rst_n)
    strobe && st_q == ST_QUIET && above && axis_ctl_q[`AXIS_SUPPRESS_BIT]
      |-> single_evt && !double_evt ##1 st_q == ST_DRAIN;
  endproperty
  a_suppress_kills: assert property (p_suppress_kills) else $error("suppress ignored");

  property p_gap_to_span;
    @(posedge core_clk) disable iff (!rst_n)
    strobe && st_q == ST_QUIET && !above && cnt_inc >= gap_lim |=> st_q == ST_SPAN && cnt_q == 9'h000;
  endproperty
  a_gap_to_span: assert property (p_gap_to_span) else $error("window did not open");

  property p_long_second;
    @(posedge core_clk) disable iff (!rst_n)
    strobe && st_q == ST_SECND && above && cnt_inc > len_lim |-> !double_evt ##1 st_q == ST_DRAIN;
  endproperty
  a_long_second: assert property (p_long_second) else $error("overlong second tap accepted");

  property p_axis_recorded;
    @(posedge core_clk) disable iff (!rst_n)
    double_evt && irq_en_q[`IRQ_DOUBLE_BIT] |=> tap_axis_q == $past(first_axis_q);
  endproperty
  a_axis_recorded: assert property (p_axis_recorded) else $error("tap axis not recorded");

  property p_single_immediate;
    @(posedge core_clk) disable iff (!rst_n)
    strobe && st_q == ST_FIRST && !above && !dbl_path |-> single_evt ##1 st_q == ST_IDLE;
  endproperty
  a_single_immediate: assert property (p_single_immediate) else $error("single tap late");

  property p_reply_done;
    @(posedge link_clk) disable iff (!rst_n)
    reg_done |-> !reg_busy && $past(reg_busy);
  endproperty
  a_reply_done: assert property (p_reply_done) else $error("done without pending request");
endmodule
`default_nettype wire

// File: test/host_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_model
  import tap_pkg::*;
(
  input  wire logic           link_clk,
  output var  logic           reg_req,
  output var  logic           reg_write,
  output var  tap_pkg::reg_addr_t reg_addr,
  output var  tap_pkg::reg_byte_t reg_wdata,
  input  wire logic           reg_done
);
  initial begin
    reg_req = 1'b0;
    reg_write = 1'b0;
    reg_addr = 6'h00;
    reg_wdata = 8'h00;
  end
  // one request outstanding; the next waits for the answer of this one
  task automatic xfer(input logic w, input reg_addr_t a, input reg_byte_t d);
    int n;
    @(posedge link_clk);
    reg_req <= 1'b1;
    reg_write <= w;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge link_clk);
    reg_req <= 1'b0;
    // idle lines show the inverse, so a stale value can never pass
    reg_write <= ~w;
    reg_addr <= ~a;
    reg_wdata <= ~d;
    n = 0;
    while (reg_done !== 1'b1 && n < 20) begin
      @(posedge link_clk);
      n++;
    end
  endtask
endmodule
`default_nettype wire

// File: test/test_tap_detect_and_link_sleep.sv
`timescale 1ns/1ps
`default_nettype none
`include "tap_consts.svh"
module test_tap_detect_and_link_sleep;
  import tap_pkg::*;
  logic        core_clk, link_clk, rst_n, reg_req, reg_write, reg_busy, reg_done;
  logic        sample_valid, odr_valid, improved_tap, act_event, inact_event;
  logic        link_enable, auto_sleep, irq_out, asleep;
  reg_addr_t   reg_addr;
  reg_byte_t   reg_wdata, reg_rdata, d;
  sample_t     sample_x, sample_y, sample_z;
  int          errors, checks_done;
  logic [31:0] lfsr_q;
  reg_byte_t   exp_q[$], msk_q[$];
  reg_addr_t   ofs[9] = '{6'h1D, 6'h21, 6'h22, 6'h23, 6'h2A, 6'h2B, 6'h2E, 6'h30, 6'h3F};

  tap_detect_and_link_sleep u_tap_detect_and_link_sleep (.core_clk(core_clk), .rst_n(rst_n),
    .link_clk(link_clk), .reg_req(reg_req), .reg_write(reg_write), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_busy(reg_busy), .reg_done(reg_done), .reg_rdata(reg_rdata),
    .sample_x(sample_x), .sample_y(sample_y), .sample_z(sample_z),
    .sample_valid(sample_valid), .odr_valid(odr_valid), .improved_tap(improved_tap),
    .act_event(act_event), .inact_event(inact_event), .link_enable(link_enable),
    .auto_sleep(auto_sleep), .irq_out(irq_out), .asleep(asleep));
  host_model u_host_model (.link_clk(link_clk), .reg_req(reg_req), .reg_write(reg_write),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_done(reg_done));

  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  // link clock offset by 7 ns; every fifth link edge (every 120 ns) still lines up with a falling core edge
  initial begin
    link_clk = 1'b0;
    #7;
    forever #24 link_clk = ~link_clk;
  end

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic check(input reg_byte_t seen, input reg_byte_t exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic wr(input reg_addr_t a, input reg_byte_t v);
    exp_q.push_back(8'h00);
    msk_q.push_back(8'h00);
    u_host_model.xfer(1'b1, a, v);
  endtask

  task automatic rd(input reg_addr_t a, input reg_byte_t e, input reg_byte_t m);
    exp_q.push_back(e);
    msk_q.push_back(m);
    u_host_model.xfer(1'b0, a, 8'h00);
  endtask

  // the host answers events by reading the cause register; the link test leaves one activity flag pending
  task automatic cause(input reg_byte_t e);
    rd(`IRQ_CAUSE_OFS, e, 8'hFF);
  endtask

  // n strobes; hi puts a random magnitude of at least 0x300 of either sign on axis ax
  task automatic hit(input int n, input int ax, input logic odr, input logic hi);
    sample_t v;
    sample_t lo;
    repeat (n) begin
      lfsr_q = lfsr_next(lfsr_q);
      lo = {8'h00, lfsr_q[7:0]};
      v = lfsr_q[0] ? 16'h0300 + lfsr_q[15:8] : 16'hFD00 - lfsr_q[15:8];
      if (!hi)
        v = lo;
      @(posedge core_clk);
      sample_x <= (ax == 0) ? v : lo;
      sample_y <= (ax == 1) ? v : lo;
      sample_z <= (ax == 2) ? v : lo;
      sample_valid <= !odr;
      odr_valid <= odr;
      @(posedge core_clk);
      sample_valid <= 1'b0;
      odr_valid <= 1'b0;
    end
  endtask

  task automatic ev(input logic a);
    @(posedge core_clk);
    act_event <= a;
    inact_event <= !a;
    @(posedge core_clk);
    act_event <= 1'b0;
    inact_event <= 1'b0;
    repeat (6) @(posedge core_clk);
  endtask

  always @(posedge link_clk) begin
    if (reg_done === 1'b1 && exp_q.size() > 0) begin
      check(8'(reg_busy), 8'h00);
      if (msk_q[0] !== 8'h00)
        check(reg_rdata & msk_q[0], exp_q[0]);
      void'(exp_q.pop_front());
      void'(msk_q.pop_front());
    end
  end

  initial begin
    #300000;
    errors++;
    end_sim();
  end

  initial begin
    {rst_n, sample_valid, odr_valid, improved_tap, act_event, inact_event} = 6'h00;
    {link_enable, auto_sleep, sample_x, sample_y, sample_z} = 50'h0;
    errors = 0;
    checks_done = 0;
    lfsr_q = 32'h435C4E71;
    repeat (8) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    check(irq_out, 8'h01 & 8'h00);
    check(asleep, 8'h00);
    foreach (ofs[i]) rd(ofs[i], 8'h00, 8'hFF);
    for (int i = 0; i < 7; i++) begin
      lfsr_q = lfsr_next(lfsr_q);
      d = lfsr_q[7:0];
      wr(ofs[i], d);
      if (i == 5)
        rd(ofs[i], 8'h00, 8'hFF);
      else
        rd(ofs[i], (i == 4) ? d & 8'h0F : d, 8'hFF);
    end
    $display("test registers finished");
    wr(`TAP_THRESHOLD_OFS, 8'h30);
    wr(`TAP_MAX_LENGTH_OFS, 8'h10);
    wr(`TAP_QUIET_GAP_OFS, 8'h11);
    wr(`SECOND_TAP_SPAN_OFS, 8'h41);
    wr(`IRQ_ENABLE_OFS, 8'h40);
    wr(`TAP_AXIS_CTRL_OFS, 8'h01);
    hit(4, 0, 1'b0, 1'b1);
    hit(6, 0, 1'b0, 1'b0);
    check(irq_out, 8'h01);
    cause(8'h40);
    rd(`MOTION_STATUS_OFS, 8'h01, 8'hFF);
    cause(8'h00);
    check(irq_out, 8'h00);
    hit(4, 1, 1'b0, 1'b1);
    hit(6, 0, 1'b0, 1'b0);
    cause(8'h00);
    hit(30, 0, 1'b0, 1'b1);
    hit(6, 0, 1'b0, 1'b0);
    cause(8'h00);
    hit(4, 0, 1'b1, 1'b1);
    hit(6, 0, 1'b1, 1'b0);
    cause(8'h00);
    improved_tap <= 1'b1;
    hit(4, 0, 1'b1, 1'b1);
    hit(6, 0, 1'b1, 1'b0);
    cause(8'h40);
    improved_tap <= 1'b0;
    wr(`IRQ_ENABLE_OFS, 8'h00);
    hit(4, 0, 1'b0, 1'b1);
    hit(6, 0, 1'b0, 1'b0);
    check(irq_out, 8'h00);
    rd(`IRQ_CAUSE_OFS, 8'h00, 8'hFF);
    $display("test single finished");
    wr(`IRQ_ENABLE_OFS, 8'h60);
    wr(`TAP_AXIS_CTRL_OFS, 8'h04);
    hit(4, 2, 1'b0, 1'b1);
    hit(8, 0, 1'b0, 1'b0);
    check(irq_out, 8'h00);
    hit(36, 0, 1'b0, 1'b0);
    hit(4, 2, 1'b0, 1'b1);
    hit(140, 0, 1'b0, 1'b0);
    cause(8'h60);
    rd(`MOTION_STATUS_OFS, 8'h04, 8'hFF);
    wr(`TAP_AXIS_CTRL_OFS, 8'h0C);
    hit(4, 2, 1'b0, 1'b1);
    hit(10, 0, 1'b0, 1'b0);
    hit(1, 2, 1'b0, 1'b1);
    hit(29, 0, 1'b0, 1'b0);
    hit(4, 2, 1'b0, 1'b1);
    hit(200, 0, 1'b0, 1'b0);
    cause(8'h40);
    wr(`TAP_AXIS_CTRL_OFS, 8'h04);
    // a tap still high at window open, then an overlong second tap
    for (int k = 0; k < 2; k++) begin
      hit(4, 2, 1'b0, 1'b1);
      hit(k ? 40 : 30, 0, 1'b0, 1'b0);
      hit(k ? 30 : 10, 2, 1'b0, 1'b1);
      hit(200, 0, 1'b0, 1'b0);
      cause(8'h40);
    end
    $display("test double finished");
    wr(`IRQ_ENABLE_OFS, 8'h18);
    link_enable <= 1'b1;
    auto_sleep <= 1'b1;
    ev(1'b1);
    cause(8'h00);
    ev(1'b0);
    check(asleep, 8'h01);
    check(irq_out, 8'h01);
    rd(`MOTION_STATUS_OFS, 8'h0C, 8'hFF);
    cause(8'h08);
    ev(1'b0);
    cause(8'h00);
    ev(1'b1);
    check(asleep, 8'h00);
    ev(1'b0);
    check(asleep, 8'h00);
    cause(8'h18);
    $display("test link finished");
    @(posedge link_clk);
    check(8'(exp_q.size()), 8'h00);
    end_sim();
  end
endmodule
`default_nettype wire
